// ===== design/backlight_params.svh
// Register map, reset values, field positions and timing counts.
`ifndef BACKLIGHT_PARAMS_SVH
`define BACKLIGHT_PARAMS_SVH

`define REG_DIM_MODE 8'h00
`define REG_MAPPING 8'h03
`define REG_BRIGHT_HI 8'h04
`define REG_BRIGHT_LO 8'h05
`define REG_RAMP_CTRL 8'h06
`define REG_SOURCE 8'h07

`define RST_DIM_MODE 8'h01
`define RST_MAPPING 8'h04
`define RST_BRIGHT 8'h00
`define RST_RAMP_CTRL 8'ha8
`define RST_SOURCE 8'h00

`define MAP_EXP_BIT 7
`define SRC_SEL_LSB 0
`define RATE_LSB 5
`define DIM_LSB 0

`define CLK_MHZ 40
`define CODE_FULL 12'hfff
`define DUTY_WINDOW 4096
`define EXP_SCALE 11'd287

`define FADE_CYC(ns) ((ns) * `CLK_MHZ / 1000)
`define RATE_CYC(khz) ((`CLK_MHZ * 1000) / (khz))
`define SLOPE_STEPS 4096
`define SLOPE_MAX_MS 1024
`define SLOPE_STEP_CYC(ms) ((ms) * `CLK_MHZ * 1000 / `SLOPE_STEPS)

`endif

// ===== design/bl_pkg.sv
// Types shared by the brightness path.
package bl_pkg;

    typedef enum logic [1:0] {
        SRC_PWM = 2'b00,
        SRC_SERIAL = 2'b01,
        SRC_PRODUCT = 2'b10,
        SRC_RESERVED = 2'b11
    } src_sel_type;

    typedef enum logic [1:0] {
        DIM_PWM = 2'b00,
        DIM_DC = 2'b01,
        DIM_MIXED = 2'b10,
        DIM_MIXED_26K = 2'b11
    } dim_mode_type;

    typedef enum logic {
        RAMP_IDLE = 1'b0,
        RAMP_RUN = 1'b1
    } ramp_state_type;

    typedef struct packed {
        logic [1:0] filter;
        logic [2:0] slope;
        logic [2:0] fade;
    } ramp_cfg_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_access_type;

    typedef struct packed {
        logic [11:0] code;
        logic zero;
        logic full;
        logic valid;
    } duty_type;

endpackage : bl_pkg

// ===== design/pwm_duty_meter.sv
// Measures the duty of the PWM input over a fixed window of samples.
`timescale 1ns/100ps
`include "backlight_params.svh"

module pwm_duty_meter #(
    parameter int WINDOW = `DUTY_WINDOW
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [2:0] rate_code,
    input wire logic pwm_duty_input,
    output bl_pkg::duty_type duty
);
    import bl_pkg::*;

    localparam int CW = $clog2(WINDOW + 1);

    logic [7:0] tick_count;
    logic [CW-1:0] sample_count;
    logic [CW-1:0] high_count;

    // Auto detection runs at the fastest rate, so any input period fits.
    wire [7:0] tick_period =
        rate_code == 3'h1 ? 8'(`RATE_CYC(500)) :
        rate_code == 3'h2 ? 8'(`RATE_CYC(1000)) :
        rate_code == 3'h3 ? 8'(`RATE_CYC(2000)) :
        rate_code == 3'h4 ? 8'(`RATE_CYC(4000)) :
        rate_code == 3'h5 ? 8'(`RATE_CYC(8000)) :
        8'(`RATE_CYC(16000));
    wire tick = tick_count >= tick_period - 8'h01;
    wire window_end = tick && sample_count == CW'(WINDOW - 1);
    wire [CW-1:0] high_total = high_count + CW'(pwm_duty_input);
    wire [11:0] duty_code =
        12'((32'(high_total) * 32'd4095) / WINDOW);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tick_count <= 8'h00;
        end else begin
            tick_count <= tick ? 8'h00 : tick_count + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sample_count <= '0;
            high_count <= '0;
        end else if (tick) begin
            sample_count <= window_end ? '0 : sample_count + CW'(1);
            high_count <= window_end ? '0 : high_total;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            duty <= '0;
        end else if (window_end) begin
            duty <= '{code: duty_code,
                      zero: high_total == '0,
                      full: high_total == CW'(WINDOW),
                      valid: 1'b1};
        end else begin
            duty.valid <= 1'b0;
        end
    end

endmodule : pwm_duty_meter

// ===== design/brightness_exp_map.sv
// Turns an 11-bit exponent into a linear current code, 1.00304 per step.
`timescale 1ns/100ps
`include "backlight_params.svh"

module brightness_exp_map (
    input wire logic [10:0] exponent,
    output logic [11:0] code
);
    import bl_pkg::*;

    // The power is split into a whole power of two and a fraction; the
    // fraction is linearised, which costs under seven percent of accuracy.
    wire [19:0] scaled = 20'(exponent) * 20'(`EXP_SCALE);
    wire [3:0] whole = scaled[19:16];
    wire [7:0] frac = scaled[15:8];
    wire [16:0] mantissa = {8'h00, 1'b1, frac} << whole;

    // Exponent zero still yields the minimum current; the caller blanks it.
    assign code = mantissa[16:5];

endmodule : brightness_exp_map

// ===== design/backlight_brightness_control.sv
// Brightness source selection, current mapping and fading of the LED sinks.
`timescale 1ns/100ps
`include "backlight_params.svh"

module backlight_brightness_control #(
    parameter int SLOPE_STEP_MAX = `SLOPE_STEP_CYC(`SLOPE_MAX_MS),
    parameter int DUTY_WINDOW = `DUTY_WINDOW
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input bl_pkg::reg_access_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic pwm_duty_input,
    output logic [11:0] led_sink_current,
    output logic led_on,
    output logic ramp_busy
);
    import bl_pkg::*;

    logic [7:0] dim_mode_reg;
    logic [7:0] mapping_reg;
    logic [7:0] bright_hi;
    logic [7:0] bright_hi_stage;
    logic [7:0] bright_lo;
    logic [7:0] ramp_ctrl;
    logic [7:0] source_reg;
    logic [11:0] target_code;
    logic [11:0] ramp_code;
    logic [23:0] step_count;
    ramp_state_type state;
    duty_type duty;
    logic [11:0] exp_code;

    // Register decode. A write lands on the edge that presents it; there
    // is no acknowledge, so writes may follow each other every cycle.
    wire wr_mode = reg_req.wr && reg_req.addr == `REG_DIM_MODE;
    wire wr_map = reg_req.wr && reg_req.addr == `REG_MAPPING;
    wire wr_hi = reg_req.wr && reg_req.addr == `REG_BRIGHT_HI;
    wire wr_lo = reg_req.wr && reg_req.addr == `REG_BRIGHT_LO;
    wire wr_ramp = reg_req.wr && reg_req.addr == `REG_RAMP_CTRL;
    wire wr_src = reg_req.wr && reg_req.addr == `REG_SOURCE;

    wire [7:0] next_rdata =
        reg_req.addr == `REG_DIM_MODE ? dim_mode_reg :
        reg_req.addr == `REG_MAPPING ? mapping_reg :
        reg_req.addr == `REG_BRIGHT_HI ? bright_hi :
        reg_req.addr == `REG_BRIGHT_LO ? bright_lo :
        reg_req.addr == `REG_RAMP_CTRL ? ramp_ctrl :
        reg_req.addr == `REG_SOURCE ? source_reg :
        8'h00;

    // Field extraction.
    wire dim_mode_type dim_mode = dim_mode_type'(dim_mode_reg[`DIM_LSB +: 2]);
    // Code 11 is reserved; every selector below falls through to the PWM
    // input for it, the same as the reset choice.
    wire src_sel_type src_sel =
        src_sel_type'(source_reg[`SRC_SEL_LSB +: 2]);
    wire [2:0] rate_code = source_reg[`RATE_LSB +: 3];
    wire ramp_cfg_type cfg = ramp_cfg_type'(ramp_ctrl);
    // Both mixed modes ramp like DC dimming; only PWM dimming bypasses it.
    wire dc_mode = dim_mode != DIM_PWM;
    wire map_exp = mapping_reg[`MAP_EXP_BIT] && dc_mode;
    wire [11:0] serial_code = {bright_hi[3:0], bright_lo};

    // The meter runs in every mode; PWM dimming takes its result unmapped.
    pwm_duty_meter #(
        .WINDOW(DUTY_WINDOW)
    ) u_duty (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .rate_code(rate_code),
        .pwm_duty_input(pwm_duty_input),
        .duty(duty)
    );

    // Serial codes above 2047 saturate the exponent rather than wrap.
    wire [10:0] serial_exp =
        serial_code[11] ? 11'h7ff : serial_code[10:0];
    // The duty drops its lowest bit to fit the 11-bit exponent; that half
    // step is finer than the mapping can resolve.
    wire [10:0] exp_in =
        src_sel == SRC_SERIAL ? serial_exp : duty.code[11:1];

    brightness_exp_map u_exp (
        .exponent(exp_in),
        .code(exp_code)
    );

    // The product is scaled back to 12 bits by the top half of the result.
    wire [23:0] product = 24'(serial_code) * 24'(duty.code);
    wire [11:0] product_code =
        duty.zero ? 12'h000 :
        duty.full ? `CODE_FULL :
        product[23:12];

    wire [11:0] pwm_src_code =
        duty.zero ? 12'h000 :
        map_exp ? exp_code :
        duty.code;
    wire [11:0] serial_src_code =
        serial_code == 12'h000 ? 12'h000 :
        map_exp ? exp_code :
        serial_code;

    // Product source ignores the mapping bit: it is linear only.
    wire [11:0] next_target =
        src_sel == SRC_SERIAL ? serial_src_code :
        src_sel == SRC_PRODUCT ? product_code :
        pwm_src_code;

    // In PWM dimming the input drives the sinks with no mapping.
    wire [11:0] direct_code =
        src_sel == SRC_SERIAL ? serial_code :
        src_sel == SRC_PRODUCT ? product_code :
        duty.code;

    // Step pacing: the longer of the fade time and the slope share.
    wire [11:0] fade_cyc =
        cfg.fade == 3'h0 ? 12'(`FADE_CYC(500)) :
        cfg.fade == 3'h1 ? 12'(`FADE_CYC(1000)) :
        cfg.fade == 3'h2 ? 12'(`FADE_CYC(2000)) :
        cfg.fade == 3'h3 ? 12'(`FADE_CYC(4000)) :
        cfg.fade == 3'h4 ? 12'(`FADE_CYC(8000)) :
        cfg.fade == 3'h5 ? 12'(`FADE_CYC(16000)) :
        cfg.fade == 3'h6 ? 12'(`FADE_CYC(32000)) :
        12'(`FADE_CYC(64000));

    wire [10:0] slope_ms =
        cfg.slope == 3'h0 ? 11'd0 :
        cfg.slope == 3'h1 ? 11'd1 :
        cfg.slope == 3'h2 ? 11'd8 :
        cfg.slope == 3'h3 ? 11'd128 :
        cfg.slope == 3'h4 ? 11'd256 :
        cfg.slope == 3'h5 ? 11'd512 :
        cfg.slope == 3'h6 ? 11'd768 :
        11'd1024;
    wire [23:0] slope_cyc =
        24'((SLOPE_STEP_MAX * int'(slope_ms)) / `SLOPE_MAX_MS);

    wire [23:0] step_period =
        slope_cyc > 24'(fade_cyc) ? slope_cyc : 24'(fade_cyc);
    wire step_tick = step_count >= step_period - 24'h1;

    // Distance is unsigned either way, so both directions pace alike.
    wire ramp_up = target_code > ramp_code;
    wire [11:0] ramp_diff =
        ramp_up ? target_code - ramp_code :
        ramp_code - target_code;
    wire [11:0] exp_step = ramp_diff >> 3;

    // Without a filter the ramp closes an eighth of the gap per step.
    wire [11:0] ramp_step =
        cfg.filter == 2'b00 && exp_step != 12'h000 ? exp_step :
        12'h001;
    wire [11:0] next_ramp =
        ramp_diff == 12'h000 ? ramp_code :
        ramp_up ? ramp_code + ramp_step :
        ramp_code - ramp_step;

    // Heavier smoothing follows the ramp in smaller bites, so the sinks
    // reach the target later than the slope setting alone would suggest.
    // Output smoothing trails the ramp by a shift set by the filter.
    wire out_up = ramp_code > led_sink_current;
    wire [11:0] out_diff =
        out_up ? ramp_code - led_sink_current :
        led_sink_current - ramp_code;
    wire [11:0] out_shifted = out_diff >> cfg.filter;
    wire [11:0] out_step =
        out_shifted == 12'h000 ? 12'h001 : out_shifted;
    wire [11:0] next_out =
        out_diff == 12'h000 ? led_sink_current :
        out_up ? led_sink_current + out_step :
        led_sink_current - out_step;

    // The transition is only over when both the ramp and the smoothed
    // output have reached the target.
    wire settled = ramp_diff == 12'h000 && out_diff == 12'h000;

    wire ramp_state_type next_state =
        !dc_mode || settled ? RAMP_IDLE :
        RAMP_RUN;
    wire next_on = dc_mode ? next_out != 12'h000 :
        direct_code != 12'h000;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dim_mode_reg <= `RST_DIM_MODE;
        end else begin
            dim_mode_reg <= wr_mode ? reg_req.data : dim_mode_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mapping_reg <= `RST_MAPPING;
        end else begin
            mapping_reg <= wr_map ? reg_req.data : mapping_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ramp_ctrl <= `RST_RAMP_CTRL;
        end else begin
            ramp_ctrl <= wr_ramp ? reg_req.data : ramp_ctrl;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            source_reg <= `RST_SOURCE;
        end else begin
            source_reg <= wr_src ? reg_req.data : source_reg;
        end
    end

    // The high byte waits in a stage until the low byte lands, so the
    // sinks never see a half-written code.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bright_hi_stage <= `RST_BRIGHT;
        end else begin
            bright_hi_stage <= wr_hi ? reg_req.data : bright_hi_stage;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bright_hi <= `RST_BRIGHT;
        end else begin
            bright_hi <= wr_lo ? bright_hi_stage : bright_hi;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bright_lo <= `RST_BRIGHT;
        end else begin
            bright_lo <= wr_lo ? reg_req.data : bright_lo;
        end
    end

    // Read data follows the address a cycle late; with no read strobe a
    // read has no side effect on any register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            target_code <= 12'h000;
        end else begin
            target_code <= dc_mode ? next_target : direct_code;
        end
    end

    // ramp_busy comes from next_state and led_on from next_on, so that they line up with the state
    // register and still leave the block straight from flip-flops.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= RAMP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ramp_busy <= 1'b0;
        end else begin
            ramp_busy <= next_state == RAMP_RUN;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            led_on <= 1'b0;
        end else begin
            led_on <= next_on;
        end
    end

    // The counter restarts whenever the ramp idles, so the first step of
    // a new transition always waits a full step period.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            step_count <= 24'h0;
        end else if (state == RAMP_RUN && !step_tick) begin
            step_count <= step_count + 24'h1;
        end else begin
            step_count <= 24'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ramp_code <= 12'h000;
            led_sink_current <= 12'h000;
        end else if (!dc_mode) begin
            ramp_code <= direct_code;
            led_sink_current <= direct_code;
        end else begin
            unique case (state)
                RAMP_IDLE: begin
                    ramp_code <= ramp_code;
                    led_sink_current <= led_sink_current;
                end
                RAMP_RUN: begin
                    ramp_code <= step_tick ? next_ramp : ramp_code;
                    led_sink_current <=
                        step_tick ? next_out : led_sink_current;
                end
            endcase
        end
    end

endmodule : backlight_brightness_control

// ===== sim/host_pwm_model.sv
// Host-side PWM source feeding the brightness input of the block.
`timescale 1ns/100ps

module host_pwm_model (
    input wire logic clk_sys,
    input wire logic [7:0] period,
    input wire logic [7:0] high_len,
    output logic pwm_duty_input
);
    logic [7:0] phase = 8'h00;
    logic level = 1'b0;
    assign pwm_duty_input = level;
    // The host picks a period that suits the sample rate it programs.
    always_ff @(posedge clk_sys) begin
        phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
        level <= phase < high_len;
    end
endmodule : host_pwm_model

// ===== sim/brightness_monitor.sv
// Concurrent checks on the ports of the brightness control block.
`timescale 1ns/100ps

module brightness_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input bl_pkg::reg_access_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic pwm_duty_input,
    input wire logic [11:0] led_sink_current,
    input wire logic led_on,
    input wire logic ramp_busy
);
    import bl_pkg::*;
    logic mapped;
    logic mode_wr;
    logic dim_pwm;
    logic [3:0] dc_age;
    logic dc_ok;
    assign mapped = reg_req.addr inside {8'h00, 8'h03, 8'h04, 8'h05,
                                         8'h06, 8'h07};
    assign mode_wr = reg_req.wr && reg_req.addr == 8'h00;
    assign dc_ok = dc_age == 4'hf && !dim_pwm;
    // A mode switch may leave a one-off jump in flight, so the ramp
    // checks wait until DC dimming has been steady for a while.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dc_age <= 4'h0;
            dim_pwm <= 1'b0;
        end else if (mode_wr) begin
            dc_age <= 4'h0;
            dim_pwm <= reg_req.data[1:0] == 2'b00;
        end else if (dc_age != 4'hf) begin
            dc_age <= dc_age + 4'h1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence write_then_read(logic [7:0] a);
        reg_req.wr && reg_req.addr == a ##1 reg_req.addr == a;
    endsequence
    sequence quiet_bus;
        !reg_req.wr [*3] ##0 $stable(reg_req.addr);
    endsequence
    sequence ramp_moves;
        dc_ok && $changed(led_sink_current);
    endsequence

    chk_unmapped_zero:
        assert property (!mapped |=> reg_rdata == 8'h00)
        else $error("unmapped address read back nonzero");
    chk_ramp_readback:
        assert property (write_then_read(8'h06) |=>
            reg_rdata == $past(reg_req.data, 2))
        else $error("ramp control readback wrong");
    chk_source_readback:
        assert property (write_then_read(8'h07) |=>
            reg_rdata == $past(reg_req.data, 2))
        else $error("source control readback wrong");
    chk_map_readback:
        assert property (write_then_read(8'h03) |=>
            reg_rdata == $past(reg_req.data, 2))
        else $error("mapping register readback wrong");
    chk_rdata_hold:
        assert property (quiet_bus |=> $stable(reg_rdata))
        else $error("read data moved without a write");
    chk_step_pacing:
        assert property (ramp_moves |=>
            (!dc_ok || $stable(led_sink_current)) [*8])
        else $error("ramp steps closer than one step period");
    chk_change_busy:
        assert property (ramp_moves |-> ramp_busy || $past(ramp_busy))
        else $error("current moved while ramp idle");
    chk_settle_quiet:
        assert property (dc_ok && $fell(ramp_busy) |->
            $stable(led_sink_current) [*4])
        else $error("current moved after ramp settled");
    chk_reset_quiet:
        assert property ($rose(rst_b) |->
            led_sink_current == 12'h000 && !led_on && !ramp_busy)
        else $error("outputs not cleared by reset");
endmodule : brightness_monitor

bind backlight_brightness_control brightness_monitor u_mon (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .pwm_duty_input(pwm_duty_input),
    .led_sink_current(led_sink_current),
    .led_on(led_on),
    .ramp_busy(ramp_busy)
);

// ===== sim/tb.sv
// Self-checking bench for the brightness control block.
`timescale 1ns/100ps

module tb;
    import bl_pkg::*;
    typedef struct packed {
        logic [1:0] dim;
        logic expo;
        logic [1:0] src;
        logic [11:0] code;
        logic [1:0] pw;
        logic [11:0] want;
    } case_type;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    reg_access_type reg_req = '0;
    logic [7:0] reg_rdata;
    logic pwm_duty_input;
    logic [11:0] led_sink_current;
    logic led_on;
    logic ramp_busy;
    logic [7:0] period = 8'h04;
    logic [7:0] high_len = 8'h00;
    int failures = 0;
    int cmp_count = 0;
    int tick[8] = '{2, 80, 40, 20, 10, 5, 2, 2};
    logic [7:0] ra[7] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h3f};
    logic [7:0] rv[7] = '{8'h01, 8'h04, 8'h00, 8'h00, 8'ha8, 8'h00, 8'h00};
    case_type half = '{2'h1, 1'h0, 2'h0, 12'h000, 2'h1, 12'h7ff};
    case_type rows[16] = '{
        '{2'h0, 1'h0, 2'h1, 12'h123, 2'h0, 12'h123},
        '{2'h0, 1'h0, 2'h1, 12'h000, 2'h0, 12'h000},
        '{2'h0, 1'h1, 2'h1, 12'h7ff, 2'h0, 12'h7ff},
        '{2'h0, 1'h0, 2'h0, 12'h000, 2'h1, 12'h7ff},
        '{2'h1, 1'h0, 2'h1, 12'habc, 2'h0, 12'habc},
        '{2'h1, 1'h1, 2'h1, 12'h7ff, 2'h0, 12'hfb0},
        '{2'h1, 1'h1, 2'h1, 12'hfff, 2'h0, 12'hfb0},
        '{2'h1, 1'h1, 2'h1, 12'h000, 2'h2, 12'h000},
        '{2'h1, 1'h0, 2'h0, 12'h000, 2'h2, 12'hfff},
        '{2'h1, 1'h1, 2'h0, 12'h000, 2'h2, 12'hfb0},
        '{2'h1, 1'h0, 2'h0, 12'h000, 2'h0, 12'h000},
        '{2'h1, 1'h1, 2'h0, 12'h000, 2'h0, 12'h000},
        '{2'h1, 1'h0, 2'h2, 12'h123, 2'h0, 12'h000},
        '{2'h1, 1'h0, 2'h2, 12'h123, 2'h2, 12'hfff},
        '{2'h1, 1'h0, 2'h2, 12'h800, 2'h1, 12'h3ff},
        '{2'h1, 1'h1, 2'h2, 12'h800, 2'h1, 12'h3ff}
    };

    backlight_brightness_control #(
        .SLOPE_STEP_MAX(128),
        .DUTY_WINDOW(16)
    ) u_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .pwm_duty_input(pwm_duty_input),
        .led_sink_current(led_sink_current),
        .led_on(led_on),
        .ramp_busy(ramp_busy)
    );
    host_pwm_model u_host (
        .clk_sys(clk_sys),
        .period(period),
        .high_len(high_len),
        .pwm_duty_input(pwm_duty_input)
    );

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{1'b1, a, d};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_req <= '{1'b0, a, 8'h00};
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({4'h0, reg_rdata}, {4'h0, exp});
    endtask : rd

    task automatic settle();
        int n;
        n = 0;
        while (ramp_busy !== 1'b0 && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        chk({11'h000, ramp_busy}, 12'h000);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    // Two full duty windows must pass before the new duty reaches target.
    task automatic run_row(input case_type r, input logic [2:0] rate);
        wr(8'h00, {6'h00, r.dim});
        wr(8'h03, {r.expo, 7'h04});
        wr(8'h06, 8'h00);
        wr(8'h07, {rate, 3'h0, r.src});
        wr(8'h04, {4'h0, r.code[11:8]});
        wr(8'h05, r.code[7:0]);
        period <= 8'(2 * tick[rate]);
        high_len <= r.pw == 2'h2 ? 8'hff : (r.pw == 2'h1 ? 8'(tick[rate])
                                                         : 8'h00);
        repeat (40 * tick[rate] + 8) @(posedge clk_sys);
        settle();
        chk(led_sink_current, r.want);
        chk({11'h000, led_on}, {11'h000, r.want != 12'h000});
    endtask : run_row

    task automatic gap_check(input logic [7:0] lo, input logic [11:0] exp);
        logic [11:0] last;
        int n;
        wr(8'h05, lo);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_sys);
            last = led_sink_current;
            n = 0;
            while (led_sink_current === last && n < 400) begin
                @(negedge clk_sys);
                n++;
            end
        end
        chk(12'(n + 1), exp);
        settle();
    endtask : gap_check

    task automatic complete_run();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], rv[i]);
        end
        wr(8'h00, 8'h00);
        wr(8'h07, 8'h01);
        wr(8'h04, 8'h0a);
        rd(8'h04, 8'h00);
        chk(led_sink_current, 12'h000);
        wr(8'h05, 8'h5c);
        rd(8'h05, 8'h5c);
        rd(8'h04, 8'h0a);
        chk(led_sink_current, 12'ha5c);
        foreach (rows[i]) begin
            run_row(rows[i], 3'h0);
        end
        for (int r = 0; r < 8; r++) begin
            run_row(half, 3'(r));
        end
        wr(8'h06, 8'h02);
        wr(8'h07, 8'h01);
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h00);
        settle();
        gap_check(8'hff, 12'h050);
        gap_check(8'h00, 12'h050);
        // The bench scales 1024 ms of slope down to 128 cycles per step.
        wr(8'h06, 8'h38);
        gap_check(8'hff, 12'h080);
        complete_run();
    end
endmodule : tb
